//--- core/flash_regs_pkg.sv
package flash_regs_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] TORCH_LEVEL_ADDR = 8'h04;
  localparam logic [7:0] FAULT_FLAGS_ADDR = 8'h05;
  localparam logic [7:0] IDENT_ADDR       = 8'h06;

  localparam logic [7:0] TORCH_LEVEL_RESET = 8'h00;
  localparam logic [7:0] FAULT_FLAGS_RESET = 8'h00;
  localparam logic [6:0] TORCH_LEVEL_MASK  = 7'h7f;

  // ---------------------------------------------------------------
  // fault flag bit positions
  // ---------------------------------------------------------------
  localparam int FLAG_OVERVOLTAGE  = 7;
  localparam int FLAG_VIN_MONITOR  = 6;
  localparam int FLAG_SHORT        = 5;
  localparam int FLAG_CURRENT_LIM  = 4;
  localparam int FLAG_SCALE_BACK   = 3;
  localparam int FLAG_SHUTDOWN     = 2;
  localparam int FLAG_UNDERVOLTAGE = 1;
  localparam int FLAG_TIMEOUT      = 0;

  // ---------------------------------------------------------------
  // identification register fields
  // ---------------------------------------------------------------
  localparam int IDENT_SOFT_RESET_BIT = 7;
  localparam int IDENT_DEVICE_LSB     = 3;
  localparam int IDENT_REVISION_LSB   = 0;

  // ---------------------------------------------------------------
  // die temperature thresholds, degrees celsius
  // ---------------------------------------------------------------
  localparam logic [7:0] SCALE_BACK_TEMP_C = 8'h7d;
  localparam logic [7:0] SHUTDOWN_TEMP_C   = 8'h96;

endpackage

//--- core/fault_flag_latch.sv
`timescale 1ns/10ps
`default_nettype none
module fault_flag_latch
  import flash_regs_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input  wire logic             clk,
  input  wire logic             clear_all,
  input  wire logic [WIDTH-1:0] events,
  input  wire logic             read_clear,
  output logic      [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] flags_r;
  logic [WIDTH-1:0] flags_nxt;

  // set beats the read-clear so an event in the read cycle survives
  always_comb
  begin
    flags_nxt = flags_r;
    if (clear_all)
      flags_nxt = FAULT_FLAGS_RESET[WIDTH-1:0];
    else if (read_clear)
      flags_nxt = events;
    else
      flags_nxt = flags_r | events;
  end

  always_ff @(posedge clk)
  begin
    flags_r <= flags_nxt;
  end

  assign flags = flags_r;

endmodule
`default_nettype wire

//--- core/flash_driver_status_id_regs.sv
// Operation
// - seven-bit torch level register, top bit reserved
// - flags bit7 overvoltage, bit6 monitor, bit4 limit
// - flags bit5 short, 3 scale-back, 2 shutdown, 1/0
// - writing ident bit7 forces full device reset
// - ident holds device and revision codes
// - shutdown at 150 C, never disabled
// - scale-back at 125 C when enabled, flagged
`timescale 1ns/10ps
`default_nettype none
module flash_driver_status_id_regs
  import flash_regs_pkg::*;
#(
  // arbitrary neutral identity values
  parameter logic [2:0] DEVICE_CODE   = 3'h5,
  parameter logic [2:0] REVISION_CODE = 3'h2
)
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       output_overvoltage_fault,
  input  wire logic       input_voltage_monitor_trip,
  input  wire logic       output_short_fault,
  input  wire logic       current_limit_event,
  input  wire logic       undervoltage_lockout_event,
  input  wire logic       flash_timeout_event,
  input  wire logic [7:0] die_temp_c,
  input  wire logic       scale_back_enable,
  output logic      [6:0] torch_level,
  output logic            thermal_scale_back,
  output logic            thermal_shutdown,
  output logic            device_reset
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [6:0] torch_r;
  logic [6:0] torch_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       soft_rst_r;
  logic       soft_rst_nxt;
  logic       tsb_r;
  logic       tsb_nxt;
  logic       tsd_r;
  logic       tsd_nxt;
  logic [7:0] events;
  logic [7:0] flags;
  logic       clear_all;
  logic       flags_read;

  // soft reset acts like power-on reset one cycle after the write
  assign clear_all  = reset | soft_rst_r;
  assign flags_read = reg_rd & (reg_addr == FAULT_FLAGS_ADDR);

  // ---------------------------------------------------------------
  // thermal protection
  // ---------------------------------------------------------------
  // shutdown has no enable input on purpose: only reset or soft reset (clear_all) masks it
  always_comb
  begin
    tsd_nxt = 1'b0;
    tsb_nxt = 1'b0;
    if (!clear_all)
    begin
      tsd_nxt = (die_temp_c >= SHUTDOWN_TEMP_C);
      tsb_nxt = scale_back_enable &&
                (die_temp_c >= SCALE_BACK_TEMP_C);
    end
  end

  always_ff @(posedge clk)
  begin
    tsb_r <= tsb_nxt;
    tsd_r <= tsd_nxt;
  end

  // ---------------------------------------------------------------
  // flag sources
  // ---------------------------------------------------------------
  always_comb
  begin
    events                    = 8'h00;
    events[FLAG_OVERVOLTAGE]  = output_overvoltage_fault;
    events[FLAG_VIN_MONITOR]  = input_voltage_monitor_trip;
    events[FLAG_CURRENT_LIM]  = current_limit_event;
    events[FLAG_SHORT]        = output_short_fault;
    events[FLAG_SCALE_BACK]   = tsb_r;
    events[FLAG_SHUTDOWN]     = tsd_r;
    events[FLAG_UNDERVOLTAGE] = undervoltage_lockout_event;
    events[FLAG_TIMEOUT]      = flash_timeout_event;
  end

  fault_flag_latch #(
    .WIDTH (8)
  ) u_flags (
    .clk        (clk),
    .clear_all  (clear_all),
    .events     (events),
    .read_clear (flags_read),
    .flags      (flags)
  );

  // ---------------------------------------------------------------
  // register writes and reads
  // ---------------------------------------------------------------
  always_comb
  begin
    torch_nxt    = torch_r;
    soft_rst_nxt = 1'b0;
    rdata_nxt    = rdata_r;
    if (clear_all)
    begin
      // a request in the clearing cycle is dropped, not queued
      torch_nxt = TORCH_LEVEL_RESET[6:0];
      rdata_nxt = 8'h00;
    end
    else
    begin
      if (reg_wr && reg_addr == TORCH_LEVEL_ADDR)
        torch_nxt = reg_wdata[6:0] & TORCH_LEVEL_MASK;
      if (reg_wr && reg_addr == IDENT_ADDR)
        soft_rst_nxt = reg_wdata[IDENT_SOFT_RESET_BIT];
      if (reg_rd)
      begin
        unique case (reg_addr)
          TORCH_LEVEL_ADDR: rdata_nxt = {1'b0, torch_r};
          FAULT_FLAGS_ADDR: rdata_nxt = flags;
          IDENT_ADDR:       rdata_nxt = {2'b00, DEVICE_CODE,
                                         REVISION_CODE};
          default:          rdata_nxt = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    torch_r    <= torch_nxt;
    rdata_r    <= rdata_nxt;
    soft_rst_r <= soft_rst_nxt;
  end

  assign reg_rdata          = rdata_r;
  assign torch_level        = torch_r;
  assign thermal_scale_back = tsb_r;
  assign thermal_shutdown   = tsd_r;
  assign device_reset       = soft_rst_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence torch_write_s;
    reg_wr && reg_addr == TORCH_LEVEL_ADDR && !soft_rst_r;
  endsequence

  chk_torch_write_load: assert property (
    torch_write_s |=> torch_level == $past(reg_wdata[6:0]))
    else $error("torch level not loaded");

  chk_torch_read_top: assert property (
    reg_rd && reg_addr == TORCH_LEVEL_ADDR && !soft_rst_r
    |=> reg_rdata[7] == 1'b0)
    else $error("torch reserved bit not zero");

  chk_ovp_flag_seen: assert property (
    output_overvoltage_fault && !soft_rst_r && !flags_read
    |=> flags[FLAG_OVERVOLTAGE])
    else $error("overvoltage flag missed");

  chk_vin_flag_seen: assert property (
    input_voltage_monitor_trip && !soft_rst_r |=> flags[FLAG_VIN_MONITOR])
    else $error("input monitor flag missed");

  chk_limit_flag_seen: assert property (
    current_limit_event && !soft_rst_r |=> flags[FLAG_CURRENT_LIM])
    else $error("current limit flag missed");

  chk_short_flag_seen: assert property (
    output_short_fault && !soft_rst_r |=> flags[FLAG_SHORT])
    else $error("short flag missed");

  chk_soft_reset_clears: assert property (
    reg_wr && reg_addr == IDENT_ADDR && reg_wdata[7] && !soft_rst_r
    |=> device_reset ##1 (torch_level == 7'h00 && flags == 8'h00))
    else $error("soft reset did not clear");

  chk_ident_read_value: assert property (
    reg_rd && reg_addr == IDENT_ADDR && !soft_rst_r
    |=> reg_rdata == {2'b00, DEVICE_CODE, REVISION_CODE})
    else $error("ident value wrong");

  chk_shutdown_always: assert property (
    die_temp_c >= SHUTDOWN_TEMP_C && !soft_rst_r
    |=> thermal_shutdown ##1 (flags[FLAG_SHUTDOWN] || $past(device_reset)))
    else $error("thermal shutdown missed");

  chk_scale_back_sets: assert property (
    scale_back_enable && die_temp_c >= SCALE_BACK_TEMP_C && !soft_rst_r
    |=> thermal_scale_back ##1
        (flags[FLAG_SCALE_BACK] || $past(device_reset)))
    else $error("thermal scale-back missed");

  chk_scale_back_gate: assert property (
    !scale_back_enable |=> !thermal_scale_back)
    else $error("scale-back while disabled");

  chk_read_clears_flag: assert property (
    flags_read && !soft_rst_r && events == 8'h00
    |=> reg_rdata == $past(flags) && flags == 8'h00)
    else $error("read did not return and clear flags");

  chk_flags_sticky: assert property (
    !flags_read && !soft_rst_r
    |=> (flags & $past(flags)) == $past(flags))
    else $error("flag lost without a read");

  chk_read_keeps_new: assert property (
    flags_read && !soft_rst_r
    |=> (flags & $past(events)) == $past(events))
    else $error("event in read cycle lost");

endmodule
`default_nettype wire

//--- test/host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model
(
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // one strobe per byte; data is scrambled once the strobe drops
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

//--- test/tb_flash_driver_status_id_regs.sv
`timescale 1ns/10ps
`default_nettype none
module tb_flash_driver_status_id_regs import flash_regs_pkg::*;;
  // arbitrary identity values
  localparam logic [2:0] DEV = 3'h3;
  localparam logic [2:0] REV = 3'h6;
  localparam logic [7:0] IDV = {2'b00, DEV, REV};
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic       wr, rd, sb_en = 1'b0, sb, sd, drst;
  logic [7:0] addr, wdata, rdata, temp = 8'h00;
  logic [5:0] ev = 6'h00;
  logic [6:0] torch;
  int         bad_count = 0;
  int         n_compared = 0;
  int         pos [6] = '{0, 1, 4, 5, 6, 7};
  always #25 clk = ~clk;
  host_model u_host (.clk(clk), .reg_rdata(rdata), .reg_wr(wr),
    .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata));
  flash_driver_status_id_regs #(.DEVICE_CODE(DEV), .REVISION_CODE(REV)) dut
  (.clk(clk), .reset(reset), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .flash_timeout_event(ev[0]),
    .undervoltage_lockout_event(ev[1]), .current_limit_event(ev[2]),
    .output_short_fault(ev[3]), .input_voltage_monitor_trip(ev[4]),
    .output_overvoltage_fault(ev[5]), .die_temp_c(temp),
    .scale_back_enable(sb_en), .torch_level(torch),
    .thermal_scale_back(sb), .thermal_shutdown(sd), .device_reset(drst));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    chk(d, exp);
  endtask
  task automatic t_torch();
    logic [7:0] v [3] = '{8'h15, 8'h3f, 8'hff};
    for (int i = 0; i < 3; i++)
    begin
      u_host.wr(TORCH_LEVEL_ADDR, v[i]);
      chk({1'b0, torch}, v[i] & 8'h7f);
      rchk(TORCH_LEVEL_ADDR, v[i] & 8'h7f);
    end
    u_host.wr(IDENT_ADDR, 8'h7f);
    rchk(IDENT_ADDR, IDV);
    u_host.wr(FAULT_FLAGS_ADDR, 8'hff);
    rchk(FAULT_FLAGS_ADDR, 8'h00);
    rchk(8'h07, 8'h00);
  endtask
  task automatic t_flags();
    for (int i = 0; i < 6; i++)
    begin
      @(negedge clk);
      ev = 6'h01 << i;
      @(negedge clk);
      ev = 6'h00;
      repeat (3) @(negedge clk);
      rchk(FAULT_FLAGS_ADDR, 8'h01 << pos[i]);
      rchk(FAULT_FLAGS_ADDR, 8'h00);
    end
  endtask
  // an event in the read cycle must survive the clear and show next read
  task automatic t_race();
    logic [7:0] d;
    fork
      u_host.rd(FAULT_FLAGS_ADDR, d);
      begin
        @(negedge clk);
        ev = 6'h01;
        @(negedge clk);
        ev = 6'h00;
      end
    join
    chk(d, 8'h00);
    rchk(FAULT_FLAGS_ADDR, 8'h01);
  endtask
  task automatic t_therm(input logic [7:0] t, input logic en,
    input logic esb, input logic esd, input logic [7:0] fl);
    @(negedge clk);
    temp = t;
    sb_en = en;
    repeat (4) @(negedge clk);
    chk({6'h00, sb, sd}, {6'h00, esb, esd});
    temp = 8'h00;
    repeat (4) @(negedge clk);
    rchk(FAULT_FLAGS_ADDR, fl);
  endtask
  task automatic t_soft();
    u_host.wr(TORCH_LEVEL_ADDR, 8'h3f);
    ev = 6'h20;
    @(negedge clk);
    ev = 6'h00;
    u_host.wr(IDENT_ADDR, 8'h80);
    chk({7'h00, drst}, 8'h01);
    @(negedge clk);
    chk({7'h00, drst}, 8'h00);
    chk({1'b0, torch}, TORCH_LEVEL_RESET);
    rchk(FAULT_FLAGS_ADDR, FAULT_FLAGS_RESET);
    rchk(IDENT_ADDR, IDV);
  endtask
  task report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(negedge clk);
    reset = 1'b0;
    chk({1'b0, torch}, TORCH_LEVEL_RESET);
    rchk(FAULT_FLAGS_ADDR, FAULT_FLAGS_RESET);
    rchk(IDENT_ADDR, IDV);
    t_torch();
    t_flags();
    t_race();
    t_therm(8'h7c, 1'b1, 1'b0, 1'b0, 8'h00);
    t_therm(8'h7d, 1'b1, 1'b1, 1'b0, 8'h08);
    t_therm(8'h96, 1'b0, 1'b0, 1'b1, 8'h04);
    t_therm(8'h96, 1'b1, 1'b1, 1'b1, 8'h0c);
    t_soft();
    report_and_stop();
  end
  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
